/* File: verilog/gpg_pkg.sv */
package gpg_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned P1_W   = 8;
  localparam int unsigned P2_W   = 3;
  localparam int unsigned P3_W   = 4;

  // Offsets inside the special function register window
  localparam logic [ADDR_W-1:0] P1_LATCH_OFF = 6'h01;
  localparam logic [ADDR_W-1:0] P2_LATCH_OFF = 6'h02;
  localparam logic [ADDR_W-1:0] P3_LATCH_OFF = 6'h03;
  localparam logic [ADDR_W-1:0] P3_DRIVE_OFF = 6'h04;
  localparam logic [ADDR_W-1:0] P1_PIN_OFF   = 6'h08;
  localparam logic [ADDR_W-1:0] P2_PIN_OFF   = 6'h09;
  localparam logic [ADDR_W-1:0] P3_PIN_OFF   = 6'h0a;
  localparam logic [ADDR_W-1:0] P1_SEG_OFF   = 6'h29;

  // Reset values
  localparam logic [P1_W-1:0] P1_LATCH_RST = 8'hff;
  localparam logic [P1_W-1:0] P1_SEG_RST   = 8'h00;
  localparam logic [P2_W-1:0] P2_LATCH_RST = 3'h7;
  localparam logic [P3_W-1:0] P3_LATCH_RST = 4'hf;
  localparam logic [P3_W-1:0] P3_DRIVE_RST = 4'h0;

  // Bit positions on port 2
  localparam int unsigned P2_STOP_BIT   = 0;
  localparam int unsigned P2_OSC_IN_BIT = 1;
  localparam int unsigned P2_OSC_OUT_BIT = 2;

  // Cycles from the read/write strobe (first state) to the second state
  localparam int unsigned WR_APPLY_CYC = 1;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gpg_bus_req_t;

  typedef struct packed {
    logic [P1_W-1:0]   p1_latch;
    logic [P1_W-1:0]   p1_seg;
    logic [P2_W-1:0]   p2_latch;
    logic [P3_W-1:0]   p3_latch;
    logic [P3_W-1:0]   p3_drive;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              p20_prev;
    logic              irq;
  } gpg_state_t;

endpackage : gpg_pkg

/* File: verilog/gpg_port_group.sv */
`timescale 1ns/1ns
module gpg_port_group
  import gpg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire gpg_bus_req_t      req_i,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   rvalid_o,
  input  wire logic              global_output_enable_i,
  input  wire logic              stop_mode_i,
  input  wire logic              dual_clock_i,
  input  wire logic [P1_W-1:0]   seg_data_i,
  input  wire logic              low_freq_osc_output_i,
  output logic                   low_freq_osc_input_o,
  output logic                   ext_irq_set_o,
  input  wire logic [P1_W-1:0]   p1_in_i,
  output logic [P1_W-1:0]        p1_out_o,
  output logic [P1_W-1:0]        p1_oe_n_o,
  input  wire logic [P2_W-1:0]   p2_in_i,
  output logic [P2_W-1:0]        p2_out_o,
  output logic [P2_W-1:0]        p2_oe_n_o,
  input  wire logic [P3_W-1:0]   p3_in_i,
  output logic [P3_W-1:0]        p3_out_o,
  output logic [P3_W-1:0]        p3_oe_n_o
);

  gpg_state_t st_r;
  gpg_state_t st_nxt;

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'h0;
    // First state: capture the write, apply it one cycle later
    st_nxt.wr_pend = req_i.wr;
    st_nxt.wr_addr = req_i.addr;
    st_nxt.wr_data = req_i.wdata;
    if (st_r.wr_pend)
    begin
      unique case (st_r.wr_addr)
        P1_LATCH_OFF: st_nxt.p1_latch = st_r.wr_data;
        P1_SEG_OFF:   st_nxt.p1_seg   = st_r.wr_data;
        P2_LATCH_OFF: st_nxt.p2_latch = st_r.wr_data[P2_W-1:0];
        P3_LATCH_OFF: st_nxt.p3_latch = st_r.wr_data[P3_W-1:0];
        P3_DRIVE_OFF: st_nxt.p3_drive = st_r.wr_data[P3_W-1:0];
        // Pin-level and unmapped addresses ignore writes
        default:      st_nxt.p1_latch = st_r.p1_latch;
      endcase
    end
    // Pins sampled in the read's first state; unused upper bits read zero
    if (req_i.rd)
    begin
      st_nxt.rvalid = 1'h1;
      unique case (req_i.addr)
        P1_LATCH_OFF: st_nxt.rdata = st_r.p1_latch;
        P1_SEG_OFF:   st_nxt.rdata = st_r.p1_seg;
        P2_LATCH_OFF: st_nxt.rdata = {5'h00, st_r.p2_latch};
        P3_LATCH_OFF: st_nxt.rdata = {4'h0, st_r.p3_latch};
        P3_DRIVE_OFF: st_nxt.rdata = {4'h0, st_r.p3_drive};
        // Segment-driven bits simply echo the pad; no value promised
        P1_PIN_OFF:   st_nxt.rdata = p1_in_i;
        P2_PIN_OFF:   st_nxt.rdata = {5'h00, p2_in_i};
        P3_PIN_OFF:   st_nxt.rdata = {4'h0, p3_in_i};
        default:      st_nxt.rdata = 8'h00;
      endcase
    end
    // Pad level is watched, so an output falling edge counts too
    st_nxt.p20_prev = p2_in_i[P2_STOP_BIT];
    st_nxt.irq      = st_r.p20_prev & ~p2_in_i[P2_STOP_BIT];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r          <= '0;
      st_r.p1_latch <= P1_LATCH_RST;
      st_r.p1_seg   <= P1_SEG_RST;
      st_r.p2_latch <= P2_LATCH_RST;
      st_r.p3_latch <= P3_LATCH_RST;
      st_r.p3_drive <= P3_DRIVE_RST;
      st_r.p20_prev <= 1'h1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o       = st_r.rdata;
  assign rvalid_o      = st_r.rvalid;
  assign ext_irq_set_o = st_r.irq;

  // Port 1: open drain from the latch, push-pull from the segment driver
  genvar gi;
  generate
    for (gi = 0; gi < P1_W; gi++)
    begin : g_p1
      always_comb
      begin
        if (st_r.p1_seg[gi])
        begin
          p1_out_o[gi]  = seg_data_i[gi];
          p1_oe_n_o[gi] = ~global_output_enable_i;
        end
        else
        begin
          p1_out_o[gi]  = 1'h0;
          p1_oe_n_o[gi] = ~(global_output_enable_i & ~st_r.p1_latch[gi]);
        end
      end
    end
  endgenerate

  // Port 3: drive type picks open drain or push-pull per bit
  generate
    for (gi = 0; gi < P3_W; gi++)
    begin : g_p3
      always_comb
      begin
        if (st_r.p3_drive[gi])
        begin
          p3_out_o[gi]  = st_r.p3_latch[gi];
          p3_oe_n_o[gi] = ~global_output_enable_i;
        end
        else
        begin
          p3_out_o[gi]  = 1'h0;
          p3_oe_n_o[gi] = ~(global_output_enable_i & ~st_r.p3_latch[gi]);
        end
      end
    end
  endgenerate

  // Port 2: open drain; oscillator and stop functions take precedence
  always_comb
  begin
    p2_out_o  = '0;
    p2_oe_n_o = ~({P2_W{global_output_enable_i}} & ~st_r.p2_latch);
    if (stop_mode_i)
    begin
      // Stop release input must never be fought by our own driver
      p2_oe_n_o[P2_STOP_BIT] = 1'h1;
    end
    if (dual_clock_i)
    begin
      p2_oe_n_o[P2_OSC_IN_BIT]  = 1'h1;
      p2_out_o[P2_OSC_OUT_BIT]  = low_freq_osc_output_i;
      p2_oe_n_o[P2_OSC_OUT_BIT] = 1'h0;
    end
  end

  // Oscillator sees the pad only in dual-clock mode
  assign low_freq_osc_input_o = dual_clock_i & p2_in_i[P2_OSC_IN_BIT];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_WR_S2: assert property (
    req_i.wr && req_i.addr == P1_LATCH_OFF && !st_r.wr_pend
    |=> st_r.p1_latch == $past(st_r.p1_latch)
    ##1 st_r.p1_latch == $past(req_i.wdata, 2))
    else $error("port 1 latch not updated in second state");

  AST_LATCH_HOLD: assert property (
    !st_r.wr_pend |=> $stable(st_r.p1_latch) && $stable(st_r.p3_latch))
    else $error("latch changed without a write");

  AST_RD_PIN: assert property (
    req_i.rd && req_i.addr == P3_PIN_OFF
    |=> rvalid_o && rdata_o[3:0] == $past(p3_in_i))
    else $error("pin level not sampled at read strobe");

  AST_RD_LATCH: assert property (
    req_i.rd && req_i.addr == P1_LATCH_OFF
    |=> rdata_o == $past(st_r.p1_latch))
    else $error("latch readback mismatch");

  AST_P2_UPPER: assert property (
    req_i.rd && req_i.addr == P2_PIN_OFF |=> rdata_o[7:3] == 5'h00)
    else $error("port 2 upper bits not zero");

  AST_P3_UPPER: assert property (
    req_i.rd && req_i.addr == P3_PIN_OFF |=> rdata_o[7:4] == 4'h0)
    else $error("port 3 upper bits not zero");

  AST_STOP_HIZ: assert property (
    stop_mode_i |-> p2_oe_n_o[P2_STOP_BIT])
    else $error("stop pin driven in stop mode");

  AST_OSC_PINS: assert property (
    dual_clock_i |-> p2_oe_n_o[P2_OSC_IN_BIT] && !p2_oe_n_o[P2_OSC_OUT_BIT]
    && p2_out_o[P2_OSC_OUT_BIT] == low_freq_osc_output_i)
    else $error("oscillator pins not handed over");

  AST_P3_PP: assert property (
    st_r.p3_drive[0] && global_output_enable_i
    |-> !p3_oe_n_o[0] && p3_out_o[0] == st_r.p3_latch[0])
    else $error("push-pull output wrong");

  AST_P3_OD: assert property (
    !st_r.p3_drive[1] |-> p3_oe_n_o[1] == (st_r.p3_latch[1]
    || !global_output_enable_i) && !p3_out_o[1])
    else $error("open drain output wrong");

  AST_SEG: assert property (
    st_r.p1_seg[0] && global_output_enable_i
    |-> !p1_oe_n_o[0] && p1_out_o[0] == seg_data_i[0])
    else $error("segment driver not on pin");

  AST_IRQ: assert property (
    $fell(p2_in_i[P2_STOP_BIT]) |=> ext_irq_set_o ##1 !ext_irq_set_o
    || $fell(p2_in_i[P2_STOP_BIT]))
    else $error("falling edge missed on stop pin");

  AST_RST_VAL: assert property (
    $rose(rst_n_i) |-> st_r.p1_latch == P1_LATCH_RST
    && st_r.p2_latch == P2_LATCH_RST && st_r.p3_drive == P3_DRIVE_RST)
    else $error("reset values wrong");

  AST_WR_P2: assert property (
    req_i.wr && req_i.addr == P2_LATCH_OFF
    |-> ##2 {5'h00, st_r.p2_latch} == ($past(req_i.wdata, 2) & 8'h07))
    else $error("port 2 latch not updated in second state");

  AST_WR_P3: assert property (
    req_i.wr && req_i.addr == P3_LATCH_OFF
    |-> ##2 {4'h0, st_r.p3_latch} == ($past(req_i.wdata, 2) & 8'h0f))
    else $error("port 3 latch not updated in second state");

  AST_WR_DRV: assert property (
    req_i.wr && req_i.addr == P3_DRIVE_OFF
    |-> ##2 {4'h0, st_r.p3_drive} == ($past(req_i.wdata, 2) & 8'h0f))
    else $error("port 3 drive type not updated in second state");

  AST_WR_SEG: assert property (
    req_i.wr && req_i.addr == P1_SEG_OFF
    |-> ##2 st_r.p1_seg == $past(req_i.wdata, 2))
    else $error("segment select not updated in second state");

  AST_PIN_NO_WR: assert property (
    req_i.wr && req_i.addr == P1_PIN_OFF
    |-> ##2 $stable(st_r.p1_latch) && $stable(st_r.p1_seg))
    else $error("write to pin level register changed a latch");

  AST_RV_PULSE: assert property (
    !req_i.rd |=> !rvalid_o)
    else $error("read valid without a read");

  AST_RD_P2PIN: assert property (
    req_i.rd && req_i.addr == P2_PIN_OFF
    |=> rvalid_o && rdata_o[2:0] == $past(p2_in_i))
    else $error("port 2 pin level not sampled at read strobe");

  AST_P1_OD: assert property (
    !st_r.p1_seg[2] |-> p1_oe_n_o[2] == (st_r.p1_latch[2]
    || !global_output_enable_i) && !p1_out_o[2])
    else $error("port 1 open drain output wrong");

  AST_OSC_OFF: assert property (
    !dual_clock_i |-> !low_freq_osc_input_o)
    else $error("oscillator input live in single clock");

  AST_P2_PLAIN: assert property (
    !dual_clock_i |-> p2_oe_n_o[P2_OSC_OUT_BIT]
    == (st_r.p2_latch[P2_OSC_OUT_BIT] || !global_output_enable_i))
    else $error("port 2 bit 2 not a plain port in single clock");

  AST_RST_P3: assert property (
    $rose(rst_n_i) |-> st_r.p3_latch == P3_LATCH_RST
    && st_r.p1_seg == P1_SEG_RST)
    else $error("port 3 latch or segment select reset wrong");

  AST_IRQ_SRC: assert property (
    ext_irq_set_o |-> $past(p2_in_i[P2_STOP_BIT], 2)
    && !$past(p2_in_i[P2_STOP_BIT]))
    else $error("interrupt latch set without a falling edge");

endmodule : gpg_port_group

/* File: bench/gpg_pad_model.sv */
`timescale 1ns/1ns
module gpg_pad_model #(
  parameter int W = 8
)
(
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] pad_o
);
  // Released bits show the outside level, never a stale driven value
  assign pad_o = (oe_n_i & ext_i) | (~oe_n_i & out_i);
endmodule : gpg_pad_model

/* File: bench/tb_general_purpose_port_group.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_general_purpose_port_group;
  import gpg_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
  } gpg_row_t;
  logic              clk_i = 1'h0;
  logic              rst_n_i = 1'h0;
  gpg_bus_req_t      req = '0;
  logic [DATA_W-1:0] rdata;
  logic              rvalid, osc_in, irq;
  logic              goe = 1'h1, stop = 1'h0, dual = 1'h0, osc_o = 1'h1;
  logic [P1_W-1:0]   seg = '0, e1 = 8'h3c, o1, oe1, pd1;
  logic [P2_W-1:0]   e2 = 3'h5, o2, oe2, pd2;
  logic [P3_W-1:0]   e3 = 4'ha, o3, oe3, pd3;
  int                n_errors = 0, compares = 0, cyc = 0, n_irq = 0, k;
  gpg_row_t          rows [9] = '{
    '{P1_LATCH_OFF, 8'hff}, '{P2_LATCH_OFF, 8'h07}, '{P3_LATCH_OFF, 8'h0f},
    '{P3_DRIVE_OFF, 8'h00}, '{P1_SEG_OFF, 8'h00}, '{P1_PIN_OFF, 8'h3c},
    '{P2_PIN_OFF, 8'h05}, '{P3_PIN_OFF, 8'h0a}, '{6'h3f, 8'h00}};

  gpg_port_group dut_u (
    .clk_i                  (clk_i),
    .rst_n_i                (rst_n_i),
    .req_i                  (req),
    .rdata_o                (rdata),
    .rvalid_o               (rvalid),
    .global_output_enable_i (goe),
    .stop_mode_i            (stop),
    .dual_clock_i           (dual),
    .seg_data_i             (seg),
    .low_freq_osc_output_i  (osc_o),
    .low_freq_osc_input_o   (osc_in),
    .ext_irq_set_o          (irq),
    .p1_in_i                (pd1),
    .p1_out_o               (o1),
    .p1_oe_n_o              (oe1),
    .p2_in_i                (pd2),
    .p2_out_o               (o2),
    .p2_oe_n_o              (oe2),
    .p3_in_i                (pd3),
    .p3_out_o               (o3),
    .p3_oe_n_o              (oe3)
  );
  gpg_pad_model #(.W(P1_W)) pad1_u (.out_i(o1), .oe_n_i(oe1), .ext_i(e1),
                                    .pad_o(pd1));
  gpg_pad_model #(.W(P2_W)) pad2_u (.out_i(o2), .oe_n_i(oe2), .ext_i(e2),
                                    .pad_o(pd2));
  gpg_pad_model #(.W(P3_W)) pad3_u (.out_i(o3), .oe_n_i(oe3), .ext_i(e3),
                                    .pad_o(pd3));

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic close_out();
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // One-cycle pulses, so a count per edge equals a count of edges
  always @(posedge clk_i)
  begin
    cyc++;
    if (irq === 1'b1)
      n_irq++;
    if (cyc == 5000)
    begin
      n_errors++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic do_reset();
    rst_n_i = 1'h0;
    tick(16);
    rst_n_i = 1'h1;
  endtask : do_reset

  // An edge passes after each strobe, so back-to-back calls never retoggle
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    req = '{1'h1, 1'h0, a, 8'h00};
    tick(1);
    `CHK("rvalid", 1'h1, rvalid)
    `CHK("rdata", e, rdata)
    req = '0;
    tick(1);
    `CHK("rvalid end", 1'h0, rvalid)
  endtask : rd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req = '{1'h0, 1'h1, a, d};
    tick(1);
    req = '0;
    tick(2);
  endtask : wr

  initial
  begin
    do_reset();
    foreach (rows[i])
      rd(rows[i].a, rows[i].d);
    `CHK("p1 oe_n", 8'hff, oe1)
    e1 = 8'hff;
    req = '{1'h0, 1'h1, P1_LATCH_OFF, 8'h55};
    tick(1);
    req = '0;
    `CHK("p1 oe_n", 8'hff, oe1)
    tick(WR_APPLY_CYC);
    `CHK("p1 oe_n", 8'h55, oe1)
    rd(P1_PIN_OFF, 8'h55);
    wr(P1_PIN_OFF, 8'h00);
    rd(P1_LATCH_OFF, 8'h55);
    seg = 8'h0a;
    wr(P1_SEG_OFF, 8'h0f);
    `CHK("p1 out", 8'h0a, o1)
    `CHK("p1 oe_n", 8'h50, oe1)
    goe = 1'h0;
    tick(1);
    `CHK("p1 oe_n", 8'hff, oe1)
    goe = 1'h1;
    wr(P1_SEG_OFF, 8'h00);
    // Whole-byte writes only, never a read-modify-write
    wr(P1_LATCH_OFF, 8'hff);
    e3 = 4'hf;
    wr(P3_LATCH_OFF, 8'h05);
    wr(P3_DRIVE_OFF, 8'h03);
    `CHK("p3 oe_n", 4'h4, oe3)
    `CHK("p3 out", 4'h1, o3)
    rd(P3_PIN_OFF, 8'h05);
    rd(P3_DRIVE_OFF, 8'h03);
    wr(P3_LATCH_OFF, 8'h0f);
    wr(P3_DRIVE_OFF, 8'h00);
    e2 = 3'h7;
    k = n_irq;
    wr(P2_LATCH_OFF, 8'h06);
    tick(3);
    `CHK("irq count", k + 1, n_irq)
    `CHK("p2 oe_n", 3'h6, oe2)
    rd(P2_PIN_OFF, 8'h06);
    stop = 1'h1;
    tick(1);
    `CHK("p2 oe_n", 3'h7, oe2)
    stop = 1'h0;
    wr(P2_LATCH_OFF, 8'h07);
    dual = 1'h1;
    osc_o = 1'h0;
    e2 = 3'h3;
    tick(1);
    `CHK("osc in", 1'h1, osc_in)
    `CHK("p2 oe_n", 3'h3, oe2)
    `CHK("p2 out", 1'h0, o2[P2_OSC_OUT_BIT])
    dual = 1'h0;
    tick(1);
    `CHK("osc in", 1'h0, osc_in)
    `CHK("p2 oe_n", 3'h7, oe2)
    // Reset in mid-run must undo every written latch
    wr(P1_LATCH_OFF, 8'h00);
    wr(P3_DRIVE_OFF, 8'h0f);
    do_reset();
    rd(P1_LATCH_OFF, 8'hff);
    rd(P3_DRIVE_OFF, 8'h00);
    close_out();
  end
endmodule : tb_general_purpose_port_group
